// File: rtl/cdr_ctrl.sv
// control register bank: lock-loss indication, clears, soft reset, squelch and boost
`timescale 1ns/100ps
`default_nettype none
module cdr_ctrl (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic acquiring_in,
  input wire logic rate_done_set_in,
  input wire logic squelch_pin_in,
  output logic lock_loss_indicator_out,
  output logic sticky_lock_loss_out,
  output logic rate_done_out,
  output logic soft_reset_out,
  output logic mute_data_out,
  output logic mute_clock_out,
  output logic boost_out
);
  logic [7:0] lock_reset_control_reg;
  logic [7:0] output_control_reg;
  logic sticky_reg;
  logic rate_done_reg;
  logic soft_reset_reg;
  logic squelch_sync;
  logic wr_lock;
  logic wr_out;
  logic clr_sticky;
  logic clr_done;
  logic sys_rst_req;

  cdr_sync u_squelch_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(squelch_pin_in),
    .sync_out(squelch_sync)
  );

  // falling edge of a stored bit across a write marks a 1-then-0 sequence
  function automatic logic fell(input logic old_bit, input logic new_bit);
    fell = old_bit & ~new_bit;
  endfunction

  assign wr_lock = wr_en_in && (wr_addr_in == cdr_pkg::ADDR_LOCK_RESET);
  assign wr_out = wr_en_in && (wr_addr_in == cdr_pkg::ADDR_OUTPUT_CTRL);
  assign clr_sticky = wr_lock && fell(lock_reset_control_reg[cdr_pkg::BIT_CLR_STICKY],
    wr_data_in[cdr_pkg::BIT_CLR_STICKY]);
  assign clr_done = wr_lock && fell(lock_reset_control_reg[cdr_pkg::BIT_CLR_RATE_DONE],
    wr_data_in[cdr_pkg::BIT_CLR_RATE_DONE]);
  assign sys_rst_req = wr_lock && fell(lock_reset_control_reg[cdr_pkg::BIT_SYS_RESET],
    wr_data_in[cdr_pkg::BIT_SYS_RESET]);

  // unused bits are masked off so a careless host cannot steer anything
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || soft_reset_reg) begin
      lock_reset_control_reg <= cdr_pkg::REG_RESET_VAL;
    end else if (wr_lock) begin
      lock_reset_control_reg <= wr_data_in & cdr_pkg::LOCK_RESET_USED;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || soft_reset_reg) begin
      output_control_reg <= cdr_pkg::REG_RESET_VAL;
    end else if (wr_out) begin
      output_control_reg <= wr_data_in & cdr_pkg::OUTPUT_CTRL_USED;
    end
  end

  // set wins over clear so a loss in the clearing cycle is kept
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || soft_reset_reg) begin
      sticky_reg <= 1'b0;
    end else if (acquiring_in) begin
      sticky_reg <= 1'b1;
    end else if (clr_sticky) begin
      sticky_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || soft_reset_reg) begin
      rate_done_reg <= 1'b0;
    end else if (rate_done_set_in) begin
      rate_done_reg <= 1'b1;
    end else if (clr_done) begin
      rate_done_reg <= 1'b0;
    end
  end

  // one-cycle soft reset pulse, also fed back to clear this bank
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= sys_rst_req && !soft_reset_reg;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || soft_reset_reg) begin
      lock_loss_indicator_out <= 1'b0;
      mute_data_out <= 1'b0;
      mute_clock_out <= 1'b0;
      boost_out <= 1'b0;
    end else begin
      lock_loss_indicator_out <= lock_reset_control_reg[cdr_pkg::BIT_LOCK_SEL] ?
        sticky_reg : acquiring_in;
      if (output_control_reg[cdr_pkg::BIT_SQUELCH_MODE]) begin
        mute_data_out <= squelch_sync;
        mute_clock_out <= !squelch_sync;
      end else begin
        mute_data_out <= squelch_sync;
        mute_clock_out <= squelch_sync;
      end
      boost_out <= output_control_reg[cdr_pkg::BIT_BOOST];
    end
  end

  assign sticky_lock_loss_out = sticky_reg;
  assign rate_done_out = rate_done_reg;
  assign soft_reset_out = soft_reset_reg;

  property p_sticky_holds;
    @(posedge clk_in) disable iff (sys_rst_in)
    (sticky_reg && !clr_sticky && !soft_reset_reg) |=> sticky_reg;
  endproperty
  a_sticky_holds: assert property (p_sticky_holds) else $error("sticky dropped");

  property p_sticky_sets;
    @(posedge clk_in) disable iff (sys_rst_in)
    (acquiring_in && !soft_reset_reg) |=> sticky_reg;
  endproperty
  a_sticky_sets: assert property (p_sticky_sets) else $error("sticky flag not set");

  property p_sticky_clear;
    @(posedge clk_in) disable iff (sys_rst_in)
    (clr_sticky && !acquiring_in) |=> !sticky_reg;
  endproperty
  a_sticky_clear: assert property (p_sticky_clear) else $error("sticky kept");

  property p_done_clear;
    @(posedge clk_in) disable iff (sys_rst_in)
    (clr_done && !rate_done_set_in) |=> !rate_done_reg;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done not cleared");

  property p_soft_reset;
    @(posedge clk_in) disable iff (sys_rst_in)
    (sys_rst_req && !soft_reset_reg) |=>
      soft_reset_reg ##1 (output_control_reg == cdr_pkg::REG_RESET_VAL);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset missing");

  // the pulse must not stretch, or the bank would sit in reset
  property p_soft_pulse;
    @(posedge clk_in) disable iff (sys_rst_in)
    soft_reset_reg |=> !soft_reset_reg;
  endproperty
  a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset too long");

  property p_soft_clears;
    @(posedge clk_in) disable iff (sys_rst_in)
    soft_reset_reg |=> (lock_reset_control_reg == cdr_pkg::REG_RESET_VAL) && !sticky_reg &&
      !rate_done_reg && !lock_loss_indicator_out && !boost_out;
  endproperty
  a_soft_clears: assert property (p_soft_clears) else $error("soft reset left state");

  property p_done_sets;
    @(posedge clk_in) disable iff (sys_rst_in)
    (rate_done_set_in && !soft_reset_reg) |=> rate_done_reg;
  endproperty
  a_done_sets: assert property (p_done_sets) else $error("done flag not set");

  property p_live_select;
    @(posedge clk_in) disable iff (sys_rst_in || soft_reset_reg)
    !lock_reset_control_reg[cdr_pkg::BIT_LOCK_SEL] |=>
      lock_loss_indicator_out == $past(acquiring_in);
  endproperty
  a_live_select: assert property (p_live_select) else $error("live pin wrong");

  property p_sticky_mirror;
    @(posedge clk_in) disable iff (sys_rst_in || soft_reset_reg)
    lock_reset_control_reg[cdr_pkg::BIT_LOCK_SEL] |=> lock_loss_indicator_out == $past(sticky_reg);
  endproperty
  a_sticky_mirror: assert property (p_sticky_mirror) else $error("pin not sticky");

  property p_either_or;
    @(posedge clk_in) disable iff (sys_rst_in || soft_reset_reg)
    output_control_reg[cdr_pkg::BIT_SQUELCH_MODE] |=> (mute_data_out != mute_clock_out);
  endproperty
  a_either_or: assert property (p_either_or) else $error("either-or squelch wrong");

  // a mismatch alone would also pass with the two mutes swapped
  property p_either_data;
    @(posedge clk_in) disable iff (sys_rst_in || soft_reset_reg)
    (output_control_reg[cdr_pkg::BIT_SQUELCH_MODE] && squelch_sync) |=>
      (mute_data_out && !mute_clock_out);
  endproperty
  a_either_data: assert property (p_either_data) else $error("data not muted");

  property p_combined;
    @(posedge clk_in) disable iff (sys_rst_in || soft_reset_reg)
    !output_control_reg[cdr_pkg::BIT_SQUELCH_MODE] |=> (mute_data_out == mute_clock_out);
  endproperty
  a_combined: assert property (p_combined) else $error("combined squelch wrong");

  property p_combined_mute;
    @(posedge clk_in) disable iff (sys_rst_in || soft_reset_reg)
    (!output_control_reg[cdr_pkg::BIT_SQUELCH_MODE] && squelch_sync) |=>
      (mute_data_out && mute_clock_out);
  endproperty
  a_combined_mute: assert property (p_combined_mute) else $error("both not muted");

  property p_boost;
    @(posedge clk_in) disable iff (sys_rst_in || soft_reset_reg)
    1'b1 |=> boost_out == $past(output_control_reg[cdr_pkg::BIT_BOOST]);
  endproperty
  a_boost: assert property (p_boost) else $error("boost mismatch");

  property p_reset_zero;
    @(posedge clk_in) sys_rst_in |=>
      (lock_reset_control_reg == cdr_pkg::REG_RESET_VAL) &&
      (output_control_reg == cdr_pkg::REG_RESET_VAL);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("registers not zero");
endmodule
`default_nettype wire

// File: rtl/cdr_pkg.sv
// package: register map, fields and reset values of the recovery receiver control bank
package cdr_pkg;
  localparam int DATA_W = 8;
  localparam logic [7:0] ADDR_LOCK_RESET = 8'h09;
  localparam logic [7:0] ADDR_OUTPUT_CTRL = 8'h11;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  localparam int BIT_LOCK_SEL = 7;
  localparam int BIT_CLR_STICKY = 6;
  localparam int BIT_SYS_RESET = 5;
  localparam int BIT_CLR_RATE_DONE = 3;
  localparam int BIT_SQUELCH_MODE = 1;
  localparam int BIT_BOOST = 0;
  localparam logic [7:0] LOCK_RESET_USED = 8'hE8;
  localparam logic [7:0] OUTPUT_CTRL_USED = 8'h03;
endpackage

// File: rtl/cdr_sync.sv
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/100ps
`default_nettype none
module cdr_sync (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic async_in,
  output logic sync_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // change counts only once the second and third stages agree
      if (s2_reg == s3_reg) begin
        sync_out <= s3_reg;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/cdr_host_model.sv
// host side model: hands register writes over the way the serial engine does
`timescale 1ns/100ps
`default_nettype none
module cdr_host_model (
  input wire logic clk_in,
  output logic wr_en_out,
  output logic [7:0] wr_addr_out,
  output logic [7:0] wr_data_out
);
  initial begin
    wr_en_out = 1'b0;
    wr_addr_out = 8'h00;
    wr_data_out = 8'h00;
  end
  // one-cycle strobe; afterwards the bus carries an inverted pattern, not the old byte
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_in);
    wr_en_out <= 1'b1;
    wr_addr_out <= addr;
    wr_data_out <= data;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    wr_addr_out <= ~addr;
    wr_data_out <= ~data;
  endtask
  // set then clear one bit of the lock/reset register, other bits kept at base
  task automatic pulse_bit(input int bit_idx, input logic [7:0] base);
    write_reg(cdr_pkg::ADDR_LOCK_RESET, base | 8'(1 << bit_idx));
    write_reg(cdr_pkg::ADDR_LOCK_RESET, base);
  endtask
endmodule
`default_nettype wire

// File: test/tb_cdr_ctrl.sv
// self-checking bench for the control register bank
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %b seen %b", nm, e, g); end end
module tb_cdr_ctrl;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic acquiring = 1'b0;
  logic done_set = 1'b0;
  logic squelch_pin = 1'b0;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic lock_loss_indicator, sticky, done, srst, mdat, mclk, boost;
  int failures = 0;
  int total_checks = 0;
  initial forever #2.5 clk_in = ~clk_in;
  cdr_host_model cdr_host_model_i (.clk_in(clk_in), .wr_en_out(wr_en), .wr_addr_out(wr_addr),
    .wr_data_out(wr_data));
  cdr_ctrl cdr_ctrl_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .wr_en_in(wr_en),
    .wr_addr_in(wr_addr), .wr_data_in(wr_data), .acquiring_in(acquiring),
    .rate_done_set_in(done_set), .squelch_pin_in(squelch_pin),
    .lock_loss_indicator_out(lock_loss_indicator), .sticky_lock_loss_out(sticky), .rate_done_out(done),
    .soft_reset_out(srst), .mute_data_out(mdat), .mute_clock_out(mclk), .boost_out(boost));
  // look just after the edge so the design's updates have landed
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    wait_cycles(1);
    `CHECK("idle", 7'h00, {lock_loss_indicator, sticky, done, srst, mdat, mclk, boost})
    @(posedge clk_in);
    acquiring <= 1'b1;
    wait_cycles(3);
    `CHECK("live_on", 2'h3, {lock_loss_indicator, sticky})
    @(posedge clk_in);
    acquiring <= 1'b0;
    wait_cycles(3);
    `CHECK("live_off", 2'h1, {lock_loss_indicator, sticky})
    cdr_host_model_i.write_reg(cdr_pkg::ADDR_LOCK_RESET, 8'h80);
    wait_cycles(3);
    `CHECK("sticky_pin", 1'h1, lock_loss_indicator)
    cdr_host_model_i.pulse_bit(6, 8'h80);
    wait_cycles(3);
    `CHECK("sticky_clr", 2'h0, {lock_loss_indicator, sticky})
    @(posedge clk_in);
    done_set <= 1'b1;
    @(posedge clk_in);
    done_set <= 1'b0;
    wait_cycles(3);
    `CHECK("done_set", 1'h1, done)
    cdr_host_model_i.pulse_bit(3, 8'h80);
    wait_cycles(3);
    `CHECK("done_clr", 1'h0, done)
    for (int v = 0; v < 4; v++) begin
      for (int sq = 0; sq < 2; sq++) begin
        cdr_host_model_i.write_reg(cdr_pkg::ADDR_OUTPUT_CTRL, 8'(v));
        @(posedge clk_in);
        squelch_pin <= sq[0];
        wait_cycles(8);
        `CHECK("boost", v[0], boost)
        `CHECK("mute_data", sq[0], mdat)
        `CHECK("mute_clock", v[1] ? ~sq[0] : sq[0], mclk)
      end
    end
    // unmapped address must leave the stored boost alone
    cdr_host_model_i.write_reg(8'h0A, 8'h00);
    wait_cycles(3);
    `CHECK("unmapped", 1'h1, boost)
    @(posedge clk_in);
    acquiring <= 1'b1;
    @(posedge clk_in);
    acquiring <= 1'b0;
    wait_cycles(3);
    cdr_host_model_i.pulse_bit(5, 8'h00);
    // the pulse stands one cycle from the edge that took the write, so look inside it
    #1;
    for (int i = 0; i < 8 && srst !== 1'b1; i++) wait_cycles(1);
    `CHECK("soft_reset", 1'h1, srst)
    wait_cycles(2);
    `CHECK("after_reset", 3'h0, {lock_loss_indicator, sticky, boost})
    end_of_test();
  end
endmodule
`default_nettype wire
